// file: fdscr_regs.sv
// Serial slave and configuration register bank of the flash driver
`timescale 1ns/1ps
`default_nettype none
module fdscr_regs #(
	parameter int SYNC_STAGES = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Serial bus pins
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Device pins and core status
	input wire logic chipEnable,
	input wire logic flashTrigger,
	input wire logic criticalFault,
	// Configuration to the core
	output fdscr_pkg::fdscr_cfg_t cfg,
	output logic flashFire
);
	localparam int NPIN = 4;
	localparam int P_SCL = 0;
	localparam int P_SDA = 1;
	localparam int P_EN = 2;
	localparam int P_TRIG = 3;

	// Raw pin vector
	logic [NPIN-1:0] pinRaw;
	assign pinRaw = {flashTrigger, chipEnable, sdaIn, scl};

	// Three-stage synchronisers, level accepted when the last two agree
	logic [NPIN-1:0] pinFilt_q;
	logic [NPIN-1:0] pinPrev_q;
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : gSync
			logic [SYNC_STAGES-1:0] stage_q;
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					stage_q <= '1;
				end else begin
					stage_q <= {stage_q[SYNC_STAGES-2:0], pinRaw[gi]};
				end
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					pinFilt_q[gi] <= 1'b1;
					pinPrev_q[gi] <= 1'b1;
				end else begin
					if (stage_q[SYNC_STAGES-1] == stage_q[SYNC_STAGES-2]) begin
						pinFilt_q[gi] <= stage_q[SYNC_STAGES-1];
					end
					pinPrev_q[gi] <= pinFilt_q[gi];
				end
			end
		end
	endgenerate

	// Bus events from filtered levels
	logic sclRise, sclFall, busStart, busStop, enRise, trigRise;
	assign sclRise = pinFilt_q[P_SCL] & ~pinPrev_q[P_SCL];
	assign sclFall = ~pinFilt_q[P_SCL] & pinPrev_q[P_SCL];
	assign busStart = pinFilt_q[P_SCL] & pinPrev_q[P_SCL] & pinPrev_q[P_SDA] & ~pinFilt_q[P_SDA];
	assign busStop = pinFilt_q[P_SCL] & pinPrev_q[P_SCL] & ~pinPrev_q[P_SDA] & pinFilt_q[P_SDA];
	assign enRise = pinFilt_q[P_EN] & ~pinPrev_q[P_EN];
	assign trigRise = pinFilt_q[P_TRIG] & ~pinPrev_q[P_TRIG];

	// Register storage
	logic [7:0] pinTimer_q, current_q, outMode_q;

	// Read decode, used by the load of the first and later read bits
	function automatic logic [7:0] readReg(input logic [7:0] sub, input logic [7:0] pt,
		input logic [7:0] cs, input logic [7:0] om);
		case (sub)
			fdscr_pkg::SUB_DESIGN_INFO: readReg = fdscr_pkg::DESIGN_INFO_VALUE;
			fdscr_pkg::SUB_PIN_TIMER: readReg = pt;
			fdscr_pkg::SUB_CURRENT: readReg = cs;
			fdscr_pkg::SUB_OUT_MODE: readReg = om;
			default: readReg = 8'h00;
		endcase
	endfunction

	// Serial engine state
	fdscr_pkg::fdscr_state_t state_q;
	logic [7:0] shift_q;
	logic [3:0] bitCnt_q;
	logic [7:0] sub_q;
	logic readDir_q;
	logic [7:0] txShift_q;
	logic wrStrobe_q;
	logic [7:0] wrData_q;
	logic [3:0] txCnt_q;
	logic [7:0] rdValue;
	assign rdValue = readReg(sub_q, pinTimer_q, current_q, outMode_q);

	// Receive shifting, MSB first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_q <= 8'h00;
			bitCnt_q <= 4'h0;
		end else if (busStart || busStop) begin
			bitCnt_q <= 4'h0;
		end else if (sclRise && (state_q == fdscr_pkg::ST_ADDR || state_q == fdscr_pkg::ST_SUB
				|| state_q == fdscr_pkg::ST_WDATA)) begin
			shift_q <= {shift_q[6:0], pinFilt_q[P_SDA]};
			bitCnt_q <= bitCnt_q + 4'h1;
		end else if (sclFall && bitCnt_q == fdscr_pkg::BYTE_BITS) begin
			bitCnt_q <= 4'h0;
		end
	end

	// Protocol sequencing, ack drive and transmit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= fdscr_pkg::ST_IDLE;
			sdaOe <= 1'b0;
			sub_q <= 8'h00;
			readDir_q <= 1'b0;
			txShift_q <= 8'h00;
			wrStrobe_q <= 1'b0;
			wrData_q <= 8'h00;
		end else begin
			wrStrobe_q <= 1'b0;
			if (busStart) begin
				state_q <= fdscr_pkg::ST_ADDR;
				sdaOe <= 1'b0;
			end else if (busStop) begin
				state_q <= fdscr_pkg::ST_IDLE;
				sdaOe <= 1'b0;
			end else if (sclFall) begin
				case (state_q)
					fdscr_pkg::ST_ADDR: begin
						if (bitCnt_q == fdscr_pkg::BYTE_BITS) begin
							if ({shift_q[7:1], 1'b0} == fdscr_pkg::WRITE_ADDR_BYTE) begin
								readDir_q <= shift_q[0];
								sdaOe <= 1'b1;
								state_q <= fdscr_pkg::ST_ADDR_ACK;
							end else begin
								state_q <= fdscr_pkg::ST_WAIT_STOP;
							end
						end
					end
					fdscr_pkg::ST_ADDR_ACK: begin
						if (readDir_q) begin
							// First read bit goes out on this fall
							txShift_q <= {rdValue[6:0], 1'b0};
							sdaOe <= ~rdValue[7];
							state_q <= fdscr_pkg::ST_TX;
						end else begin
							sdaOe <= 1'b0;
							state_q <= fdscr_pkg::ST_SUB;
						end
					end
					fdscr_pkg::ST_SUB: begin
						if (bitCnt_q == fdscr_pkg::BYTE_BITS) begin
							sub_q <= shift_q;
							sdaOe <= 1'b1;
							state_q <= fdscr_pkg::ST_SUB_ACK;
						end
					end
					fdscr_pkg::ST_SUB_ACK: begin
						sdaOe <= 1'b0;
						state_q <= fdscr_pkg::ST_WDATA;
					end
					fdscr_pkg::ST_WDATA: begin
						if (bitCnt_q == fdscr_pkg::BYTE_BITS) begin
							wrData_q <= shift_q;
							wrStrobe_q <= 1'b1;
							sdaOe <= 1'b1;
							state_q <= fdscr_pkg::ST_WDATA_ACK;
						end
					end
					fdscr_pkg::ST_WDATA_ACK: begin
						sdaOe <= 1'b0;
						state_q <= fdscr_pkg::ST_WAIT_STOP;
					end
					fdscr_pkg::ST_TX: begin
						if (txCnt_q == fdscr_pkg::BYTE_BITS - 4'h1) begin
							sdaOe <= 1'b0;
							state_q <= fdscr_pkg::ST_MACK;
						end else begin
							sdaOe <= ~txShift_q[7];
							txShift_q <= {txShift_q[6:0], 1'b0};
						end
					end
					fdscr_pkg::ST_MACK: begin
						// Master ack repeats the same register, nack ends
						if (readDir_q) begin
							txShift_q <= {rdValue[6:0], 1'b0};
							sdaOe <= ~rdValue[7];
							state_q <= fdscr_pkg::ST_TX;
						end else begin
							state_q <= fdscr_pkg::ST_WAIT_STOP;
						end
					end
					default: begin
						sdaOe <= 1'b0;
					end
				endcase
			end else if (sclRise && state_q == fdscr_pkg::ST_MACK) begin
				readDir_q <= ~pinFilt_q[P_SDA]; // Low means master wants more
			end
		end
	end

	// Transmit bit counter, counts bits already sent
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txCnt_q <= 4'h0;
		end else if (state_q != fdscr_pkg::ST_TX) begin
			txCnt_q <= 4'h0;
		end else if (sclFall) begin
			txCnt_q <= txCnt_q + 4'h1;
		end
	end

	// Register writes, defaults on reset or chip enable rise
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinTimer_q <= fdscr_pkg::PIN_TIMER_RESET;
			current_q <= fdscr_pkg::CURRENT_RESET;
			outMode_q <= fdscr_pkg::OUT_MODE_RESET;
		end else if (enRise) begin
			pinTimer_q <= fdscr_pkg::PIN_TIMER_RESET;
			current_q <= fdscr_pkg::CURRENT_RESET;
			outMode_q <= fdscr_pkg::OUT_MODE_RESET;
		end else begin
			if (wrStrobe_q && sub_q == fdscr_pkg::SUB_PIN_TIMER) begin
				pinTimer_q <= wrData_q;
			end
			if (wrStrobe_q && sub_q == fdscr_pkg::SUB_CURRENT) begin
				current_q <= wrData_q;
			end
			if (wrStrobe_q && sub_q == fdscr_pkg::SUB_OUT_MODE) begin
				outMode_q <= wrData_q;
			end
			if (criticalFault) begin
				outMode_q[fdscr_pkg::OUT_EN_BIT] <= 1'b0;
			end
		end
	end

	// Field view toward the core
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg <= '0;
		end else begin
			cfg.auxPinTwoConfig <= pinTimer_q[fdscr_pkg::AUX2_LSB +: 2];
			cfg.auxPinOneConfig <= pinTimer_q[fdscr_pkg::AUX1_LSB +: 2];
			cfg.flashTimeoutCode <= pinTimer_q[fdscr_pkg::TIMEOUT_LSB +: 4];
			cfg.flashCurrentCode <= current_q[fdscr_pkg::FLASH_I_LSB +: 5];
			cfg.torchCurrentCode <= current_q[fdscr_pkg::TORCH_I_LSB +: 3];
			cfg.inductorPeakLimit <= outMode_q[fdscr_pkg::PEAK_LSB +: 2];
			cfg.triggerLevelSelect <= outMode_q[fdscr_pkg::TRIG_LEVEL_BIT];
			cfg.switchFreqFoldback <= outMode_q[fdscr_pkg::FOLDBACK_BIT];
			cfg.outputEnable <= outMode_q[fdscr_pkg::OUT_EN_BIT] & ~criticalFault;
			cfg.triggerSourceSelect <= outMode_q[fdscr_pkg::TRIG_SRC_BIT];
			cfg.ledOutputMode <= outMode_q[fdscr_pkg::LED_MODE_LSB +: 2];
		end
	end

	// Flash firing from software or the trigger pin
	logic flashArmed, edgeLatch_q;
	assign flashArmed = outMode_q[fdscr_pkg::OUT_EN_BIT]
		&& outMode_q[fdscr_pkg::LED_MODE_LSB +: 2] == fdscr_pkg::LED_MODE_FLASH;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			edgeLatch_q <= 1'b0;
		end else if (!flashArmed) begin
			edgeLatch_q <= 1'b0;
		end else if (trigRise) begin
			edgeLatch_q <= 1'b1;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flashFire <= 1'b0;
		end else if (!flashArmed || criticalFault) begin
			flashFire <= 1'b0;
		end else if (!outMode_q[fdscr_pkg::TRIG_SRC_BIT]) begin
			flashFire <= 1'b1;
		end else if (outMode_q[fdscr_pkg::TRIG_LEVEL_BIT]) begin
			flashFire <= pinFilt_q[P_TRIG];
		end else begin
			flashFire <= edgeLatch_q | trigRise;
		end
	end

	// Open-drain data line only ever pulls low
	assign sdaOut = 1'b0;
endmodule
`default_nettype wire

// file: fdscr_pkg.sv
// Constants and types shared by the flash driver serial control registers
package fdscr_pkg;
	// Bus address and direction bytes
	localparam logic [6:0] SLAVE_ADDR = 7'h30;
	localparam logic [7:0] WRITE_ADDR_BYTE = 8'h60;
	localparam logic [7:0] READ_ADDR_BYTE = 8'h61;
	// Register subaddresses
	localparam logic [7:0] SUB_DESIGN_INFO = 8'h00;
	localparam logic [7:0] SUB_PIN_TIMER = 8'h02;
	localparam logic [7:0] SUB_CURRENT = 8'h03;
	localparam logic [7:0] SUB_OUT_MODE = 8'h04;
	// Design information value, arbitrary
	localparam logic [7:0] DESIGN_INFO_VALUE = 8'h5a;
	// Register defaults
	localparam logic [7:0] PIN_TIMER_RESET = 8'h0f;
	localparam logic [7:0] CURRENT_RESET = 8'h73;
	localparam logic [7:0] OUT_MODE_RESET = 8'ha4;
	// Field positions
	localparam int AUX2_LSB = 6;
	localparam int AUX1_LSB = 4;
	localparam int TIMEOUT_LSB = 0;
	localparam int FLASH_I_LSB = 3;
	localparam int TORCH_I_LSB = 0;
	localparam int PEAK_LSB = 6;
	localparam int TRIG_LEVEL_BIT = 5;
	localparam int FOLDBACK_BIT = 4;
	localparam int OUT_EN_BIT = 3;
	localparam int TRIG_SRC_BIT = 2;
	localparam int LED_MODE_LSB = 0;
	// Bit count of a byte, before the ack slot
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// Mode encodings
	localparam logic [1:0] LED_MODE_STANDBY = 2'h0;
	localparam logic [1:0] LED_MODE_BOOST_OUTPUT_PIN = 2'h1;
	localparam logic [1:0] LED_MODE_ASSIST = 2'h2;
	localparam logic [1:0] LED_MODE_FLASH = 2'h3;
	localparam logic [1:0] AUX1_RESERVED = 2'h3;
	// Decoded configuration presented to the analog core
	typedef struct packed {
		logic [1:0] auxPinTwoConfig;
		logic [1:0] auxPinOneConfig;
		logic [3:0] flashTimeoutCode;
		logic [4:0] flashCurrentCode;
		logic [2:0] torchCurrentCode;
		logic [1:0] inductorPeakLimit;
		logic triggerLevelSelect;
		logic switchFreqFoldback;
		logic outputEnable;
		logic triggerSourceSelect;
		logic [1:0] ledOutputMode;
	} fdscr_cfg_t;
	// Serial engine states
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK, ST_WDATA, ST_WDATA_ACK,
		ST_TX, ST_MACK, ST_WAIT_STOP
	} fdscr_state_t;
endpackage

// file: fdscr_regs_asserts.sv
// Port checks for the flash driver register bank
`timescale 1ns/1ps
`default_nettype none
module fdscr_regs_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Bus pins
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	// Device pins and outputs
	input wire logic chipEnable,
	input wire logic flashTrigger,
	input wire logic criticalFault,
	input wire fdscr_pkg::fdscr_cfg_t cfg,
	input wire logic flashFire
);
	localparam logic [23:0] CFG_DEF = {fdscr_pkg::PIN_TIMER_RESET, fdscr_pkg::CURRENT_RESET,
		fdscr_pkg::OUT_MODE_RESET};
	logic [4:0] highCnt_q;
	logic armed;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Cycles with the bus clock held high
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			highCnt_q <= 5'h00;
		end else if (!scl) begin
			highCnt_q <= 5'h00;
		end else if (highCnt_q != 5'h1f) begin
			highCnt_q <= highCnt_q + 5'h01;
		end
	end
	// Output on in flash mode
	assign armed = cfg.outputEnable && (cfg.ledOutputMode == fdscr_pkg::LED_MODE_FLASH);
	ack_stable_a: assert property ($changed(sdaOe) |-> !scl)
		else $error("data drive moved with bus clock high");
	idle_release_a: assert property (highCnt_q > 5'h0e |-> !sdaOe)
		else $error("data held low on idle bus");
	reset_default_a: assert property ($rose(reset_n) |-> ##[1:2] (cfg == CFG_DEF))
		else $error("defaults missing after reset");
	ce_default_a: assert property ($rose(chipEnable) |-> ##[3:8] (cfg == CFG_DEF))
		else $error("defaults missing after enable");
	fault_clear_a: assert property (criticalFault |-> ##2 !cfg.outputEnable)
		else $error("fault left output on");
	sw_fire_a: assert property (armed && !cfg.triggerSourceSelect && !criticalFault
		&& !$past(criticalFault) |-> ##[0:1] flashFire)
		else $error("software flash missing");
	off_quiet_a: assert property ((!cfg.outputEnable) [*3] |-> !flashFire)
		else $error("flash with output off");
	hw_fire_a: assert property ($rose(flashTrigger) && armed && cfg.triggerSourceSelect
		|-> ##[2:8] flashFire)
		else $error("trigger flash missing");
endmodule
bind fdscr_regs fdscr_regs_asserts u_asserts (.clk, .reset_n, .scl, .sdaIn, .sdaOut, .sdaOe,
	.chipEnable, .flashTrigger, .criticalFault, .cfg, .flashFire);
`default_nettype wire

// file: fdscr_host_model.sv
// Bus master model of the host processor
`timescale 1ns/1ps
`default_nettype none
module fdscr_host_model (
	// Clock
	input wire logic clk,
	// Device data drive
	input wire logic sdaOe,
	input wire logic sdaOut,
	// Bus wires
	output var logic scl,
	output logic sdaLine
);
	logic masterLow = 1'h0;
	initial scl = 1'h1;
	// Pull-up resolves the open-drain wire
	assign sdaLine = !(masterLow || (sdaOe && !sdaOut));
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Data moves only mid-low, sampled mid-high
	task automatic bit_slot(input logic b, output logic s);
		scl <= 1'h0;
		pause(5);
		masterLow <= !b;
		pause(5);
		scl <= 1'h1;
		pause(5);
		s = sdaLine;
		pause(5);
	endtask
	task automatic start_cond();
		scl <= 1'h0;
		pause(5);
		masterLow <= 1'h0;
		pause(5);
		scl <= 1'h1;
		pause(10);
		masterLow <= 1'h1;
		pause(10);
	endtask
	task automatic stop_cond();
		scl <= 1'h0;
		pause(5);
		masterLow <= 1'h1;
		pause(5);
		scl <= 1'h1;
		pause(10);
		masterLow <= 1'h0;
		pause(20);
	endtask
	// Byte out, most significant bit first
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(b[i], s);
		end
		bit_slot(1'h1, s);
		ack = !s;
	endtask
	task automatic recv_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'h1, s);
			b[i] = s;
		end
		bit_slot(nack, s);
	endtask
	// Address, subaddress, data
	task automatic write_reg(input logic [7:0] addr, sub, d, output logic [2:0] acks);
		start_cond();
		send_byte(addr, acks[2]);
		send_byte(sub, acks[1]);
		send_byte(d, acks[0]);
		stop_cond();
	endtask
	// Subaddress, repeated start, one byte, nack
	task automatic read_reg(input logic [7:0] sub, output logic [7:0] d, output logic [2:0] acks);
		start_cond();
		send_byte(fdscr_pkg::WRITE_ADDR_BYTE, acks[2]);
		send_byte(sub, acks[1]);
		start_cond();
		send_byte(fdscr_pkg::READ_ADDR_BYTE, acks[0]);
		recv_byte(1'h1, d);
		stop_cond();
	endtask
endmodule
`default_nettype wire

// file: fdscr_regs_bench.sv
// Bench for the flash driver register bank
`timescale 1ns/1ps
`default_nettype none
module fdscr_regs_bench;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic chipEnable = 1'h1;
	logic flashTrigger = 1'h0;
	logic criticalFault = 1'h0;
	logic scl, sdaIn, sdaOut, sdaOe, flashFire;
	fdscr_pkg::fdscr_cfg_t cfg;
	logic [7:0] shadow [0:4];
	logic [7:0] rd;
	logic [2:0] acks;
	int badCount = 0;
	int checksDone = 0;
	initial begin
		forever #2 clk = ~clk;
	end
	fdscr_regs #(.SYNC_STAGES(3)) u_dut (.clk, .reset_n, .scl, .sdaIn, .sdaOut, .sdaOe,
		.chipEnable, .flashTrigger, .criticalFault, .cfg, .flashFire);
	fdscr_host_model u_host (.clk, .sdaOe, .sdaOut, .scl, .sdaLine(sdaIn));
	// Expected read value of a subaddress
	function automatic logic [7:0] exp_reg(input logic [7:0] sub);
		if (sub == fdscr_pkg::SUB_DESIGN_INFO) begin
			return fdscr_pkg::DESIGN_INFO_VALUE;
		end
		return (sub inside {8'h02, 8'h03, 8'h04}) ? shadow[sub[2:0]] : 8'h00;
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] want);
		checksDone++;
		if (seen !== want) begin
			badCount++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic stopTest();
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		u_host.write_reg(fdscr_pkg::WRITE_ADDR_BYTE, sub, d, acks);
		check(acks, 3'h7);
		if (sub inside {8'h02, 8'h03, 8'h04}) begin
			shadow[sub[2:0]] = d;
		end
	endtask
	task automatic rdc(input logic [7:0] sub);
		u_host.read_reg(sub, rd, acks);
		check(acks, 3'h7);
		check(rd, exp_reg(sub));
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Watchdog
	initial begin
		#200000;
		badCount++;
		$display("unexpected at %0t: watchdog", $time);
		stopTest();
	end
	// Main sequence
	initial begin
		logic [31:0] r;
		void'($urandom(92));
		shadow[2] = fdscr_pkg::PIN_TIMER_RESET;
		shadow[3] = fdscr_pkg::CURRENT_RESET;
		shadow[4] = fdscr_pkg::OUT_MODE_RESET;
		pause(6);
		reset_n <= 1'h1;
		pause(10);
		foreach (shadow[i]) begin
			rdc(8'(i));
		end
		check(cfg, {shadow[2], shadow[3], shadow[4]});
		check(sdaOut, 1'h0);
		$display("defaults done");
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			wr(8'h02, {r[7:6], r[9:8] % 2'h3, r[3:0]});
			wr(8'h03, {r[14:10] % 5'h19, r[2:0]});
			rdc(8'h02);
			rdc(8'h03);
			check(cfg, {shadow[2], shadow[3], shadow[4]});
		end
		$display("random done");
		wr(8'h00, 8'hff);
		wr(8'h01, 8'h55);
		rdc(8'h00);
		rdc(8'h01);
		u_host.write_reg(8'h62, 8'h02, 8'h00, acks);
		check(acks, 3'h0);
		rdc(8'h02);
		$display("read only done");
		for (int m = 0; m < 4; m++) begin
			wr(8'h04, {2'(m), 1'h1, m[0], 1'h1, 1'h0, 2'(m)});
			check(cfg, {shadow[2], shadow[3], shadow[4]});
			check(flashFire, m == 3);
		end
		criticalFault <= 1'h1;
		pause(1);
		criticalFault <= 1'h0;
		pause(4);
		shadow[4][3] = 1'h0;
		check(cfg, {shadow[2], shadow[3], shadow[4]});
		check(flashFire, 1'h0);
		rdc(8'h04);
		$display("modes done");
		wr(8'h04, 8'haf);
		check(flashFire, 1'h0);
		flashTrigger <= 1'h1;
		pause(10);
		check(flashFire, 1'h1);
		flashTrigger <= 1'h0;
		pause(10);
		check(flashFire, 1'h0);
		wr(8'h04, 8'h8f);
		flashTrigger <= 1'h1;
		pause(10);
		flashTrigger <= 1'h0;
		pause(10);
		check(flashFire, 1'h1);
		wr(8'h04, 8'h00);
		check(flashFire, 1'h0);
		$display("trigger done");
		chipEnable <= 1'h0;
		pause(10);
		chipEnable <= 1'h1;
		pause(12);
		shadow[2] = fdscr_pkg::PIN_TIMER_RESET;
		shadow[3] = fdscr_pkg::CURRENT_RESET;
		shadow[4] = fdscr_pkg::OUT_MODE_RESET;
		check(cfg, {shadow[2], shadow[3], shadow[4]});
		rdc(8'h04);
		// Master ack asks for the same register again
		u_host.start_cond();
		u_host.send_byte(fdscr_pkg::WRITE_ADDR_BYTE, acks[2]);
		u_host.send_byte(8'h03, acks[1]);
		u_host.start_cond();
		u_host.send_byte(fdscr_pkg::READ_ADDR_BYTE, acks[0]);
		check(acks, 3'h7);
		for (int k = 0; k < 2; k++) begin
			u_host.recv_byte(1'(k), rd);
			check(rd, exp_reg(8'h03));
		end
		u_host.stop_cond();
		$display("enable done");
		stopTest();
	end
endmodule
`default_nettype wire
